// *** common/scdr_cfg.svh ***
`ifndef SCDR_CFG_SVH
`define SCDR_CFG_SVH
`define SCDR_ADDR_UPPER     7'h3e
`define SCDR_ADDR_LOWER     7'h3f
`define SCDR_ADDR_SUPPLY    7'h40
`define SCDR_ADDR_BTL       7'h3b
`define SCDR_ADDR_CLKSEL    7'h3c
`define SCDR_RST_UPPER      8'ha8
`define SCDR_RST_LOWER      8'h98
`define SCDR_RST_BTL        8'ha0
`define SCDR_RST_CLKSEL     2'h1
`define SCDR_RST_SUPPLY     8'h00
`define SCDR_SUPPLY_MASK    8'h5f
`define SCDR_MODE_BIT       7
`define SCDR_FRAME_BITS     5'h10
`define SCDR_ADDR_BITS      5'h08
`define SCDR_RST_DIV        4'h2
`define SCDR_BIT_BUV        6
`define SCDR_BIT_OC         4
`define SCDR_BIT_AUV        3
`define SCDR_BIT_OT         2
`define SCDR_BIT_OV         1
`define SCDR_BIT_PW         0
`endif

// *** common/scdr_pkg.sv ***
`default_nettype none
package scdr_pkg;
   typedef logic [7:0] scdr_byte_t;
   typedef logic [6:0] scdr_addr_t;
   typedef enum logic [1:0] {
      scdr_clk_80m,
      scdr_clk_40m,
      scdr_clk_20m,
      scdr_clk_10m
   } scdr_clksel_e;
endpackage
`default_nettype wire

// *** rtl/scdr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module scdr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one;

   // Two flip-flop synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end
endmodule
`default_nettype wire

// *** rtl/scdr_regs.sv ***
// Contract
// - Bit time above upper limit is clamped to the upper limit.
// - Bit time below lower limit, and not above the upper limit, is clamped to the lower limit.
// - Upper and lower limit registers are full 8-bit read-write fields.
// - Each transaction is a 16-bit frame: address-mode byte, then data byte.
// - First byte carries a 7-bit address and one access mode bit.
// - Register data bits D0 to D7 sit at frame bits 0 to 7.
// - Mode bit 0 reads the addressed register without changing it.
// - Mode bit 1 clears clearable bits of the addressed status byte.
// - Read/clear bits clear on command; read-only and reserved bits ignore it.
// - Status flags stay latched and are never cleared autonomously.
// - One address selects one whole 8-bit register per frame.
// - Supply register holds six flags at bits 6,4,3,2,1,0, all read/clear.
// - Reserved bits 7 and 5 of the supply register read zero.
// - Battery undervoltage flag sets on its detector and else reads zero.
// - Main overvoltage flag latches on a rising overvoltage report.
// - Main prewarning flag latches when the falling comparator trips.
// - Auxiliary undervoltage flag latches on auxiliary undervoltage failure.
// - Clock select codes 00..11 give 80, 40, 20 and 10 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "scdr_cfg.svh"
module scdr_regs (
   input  wire logic                 clk_sys,
   input  wire logic                 reset_n,
   input  wire logic                 spi_sck,
   input  wire logic                 spi_csn_n,
   input  wire logic                 spi_sdi,
   output logic                      spi_sdo,
   output logic                      spi_sdo_oe,
   input  wire logic                 battery_uv_det,
   input  wire logic                 aux_oc_det,
   input  wire logic                 aux_uv_det,
   input  wire logic                 aux_ot_det,
   input  wire logic                 main_ov_det,
   input  wire logic                 main_pw_det,
   output scdr_pkg::scdr_byte_t      effective_bit_time,
   output scdr_pkg::scdr_clksel_e    recovery_clock_select,
   output logic [3:0]                recovery_clock_div
);
   import scdr_pkg::*;

   logic [2:0]  pin_sync;
   logic [5:0]  det_sync;
   logic [5:0]  det_prev;
   logic        sck_prev;
   logic        cs_prev;
   logic [15:0] shift_in;
   logic [7:0]  shift_out;
   logic [4:0]  bit_count;
   logic        addr_taken;
   logic        frame_done;
   scdr_addr_t  frame_addr;
   logic        frame_mode;
   scdr_byte_t  frame_data;
   scdr_byte_t  upper_limit_field;
   scdr_byte_t  lower_limit_field;
   scdr_byte_t  bit_time_length_setting;
   scdr_byte_t  supply_fail_status_two;
   scdr_byte_t  next_supply;
   scdr_byte_t  event_bits;
   scdr_byte_t  read_data;
   logic        sck_rise;
   logic        sck_fall;
   logic        cs_low;
   logic        cs_fall;
   logic        sck_sync;
   logic        cs_active_sync;
   logic        sdi_sync;
   logic [5:0]  det_rise;
   logic        battery_undervoltage_flag;
   logic        aux_regulator_overcurrent_flag;
   logic        aux_regulator_undervoltage_flag;
   logic        aux_regulator_overtemp_flag;
   logic        main_regulator_overvoltage_flag;
   logic        main_regulator_prewarning_flag;

   function automatic scdr_byte_t reg_read(input scdr_addr_t a);
      case (a)
         `SCDR_ADDR_UPPER:  reg_read = upper_limit_field;
         `SCDR_ADDR_LOWER:  reg_read = lower_limit_field;
         `SCDR_ADDR_BTL:    reg_read = bit_time_length_setting;
         `SCDR_ADDR_CLKSEL: reg_read = {6'h00, recovery_clock_select};
         `SCDR_ADDR_SUPPLY: reg_read = {1'b0, battery_undervoltage_flag,
                                        1'b0,
                                        aux_regulator_overcurrent_flag,
                                        aux_regulator_undervoltage_flag,
                                        aux_regulator_overtemp_flag,
                                        main_regulator_overvoltage_flag,
                                        main_regulator_prewarning_flag};
         default:           reg_read = 8'h00;
      endcase
   endfunction

   // Chip select enters inverted, so the synchroniser's reset value of zero
   // equals the idle pin level and no false frame start follows reset.
   scdr_sync #(.WIDTH(3)) u_pin_sync (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .async_in ({spi_sck, ~spi_csn_n, spi_sdi}),
      .sync_out (pin_sync)
   );

   scdr_sync #(.WIDTH(6)) u_det_sync (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .async_in ({battery_uv_det, aux_oc_det, aux_uv_det,
                  aux_ot_det, main_ov_det, main_pw_det}),
      .sync_out (det_sync)
   );

   assign sck_sync       = pin_sync[2];
   assign cs_active_sync = pin_sync[1];
   assign sdi_sync       = pin_sync[0];

   assign cs_low   = cs_active_sync;
   assign sck_rise = sck_sync & ~sck_prev;
   assign sck_fall = ~sck_sync & sck_prev;
   assign cs_fall  = cs_low & ~cs_prev;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sck_prev <= 1'b0;
         cs_prev  <= 1'b0;
         det_prev <= 6'h00;
      end else begin
         sck_prev <= sck_sync;
         cs_prev  <= cs_active_sync;
         det_prev <= det_sync;
      end
   end

   // Frame receive: MSB first, bit 8 is the mode, bits 7..0 the data.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shift_in   <= 16'h0000;
         bit_count  <= 5'h00;
         frame_done <= 1'b0;
      end else begin
         frame_done <= 1'b0;
         if (!cs_low) begin
            if (bit_count == `SCDR_FRAME_BITS) begin
               frame_done <= 1'b1;
            end
            bit_count <= 5'h00;
         end else if (sck_rise && bit_count != `SCDR_FRAME_BITS) begin
            shift_in  <= {shift_in[14:0], sdi_sync};
            bit_count <= bit_count + 5'h01;
         end
      end
   end

   // Frame words: high byte address and mode, low byte data.
   assign frame_addr = shift_in[15:9];
   assign frame_mode = shift_in[8];
   assign frame_data = shift_in[7:0];

   // Transmit: after the first byte the addressed register is returned.
   // The reply is loaded before the eighth falling edge is seen, so the
   // first data bit is ready when the host samples the ninth rising edge.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         shift_out  <= 8'h00;
         addr_taken <= 1'b0;
         spi_sdo    <= 1'b0;
      end else begin
         if (!cs_low) begin
            addr_taken <= 1'b0;
         end else if (!addr_taken && bit_count == `SCDR_ADDR_BITS) begin
            addr_taken <= 1'b1;
            shift_out  <= reg_read(shift_in[7:1]);
         end else if (sck_fall && addr_taken) begin
            spi_sdo   <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
         if (cs_fall) begin
            spi_sdo <= 1'b0;
         end
      end
   end

   assign spi_sdo_oe = cs_low;

   // Control registers written when the mode bit is set.
   // A frame cut short of sixteen bits never commits, so it changes nothing.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         upper_limit_field       <= `SCDR_RST_UPPER;
         lower_limit_field       <= `SCDR_RST_LOWER;
         bit_time_length_setting <= `SCDR_RST_BTL;
         recovery_clock_select   <= scdr_clksel_e'(`SCDR_RST_CLKSEL);
      end else if (frame_done && frame_mode) begin
         case (frame_addr)
            `SCDR_ADDR_UPPER:  upper_limit_field <= frame_data;
            `SCDR_ADDR_LOWER:  lower_limit_field <= frame_data;
            `SCDR_ADDR_BTL:    bit_time_length_setting <= frame_data;
            `SCDR_ADDR_CLKSEL: recovery_clock_select <=
                                  scdr_clksel_e'(frame_data[1:0]);
            default: ;
         endcase
      end
   end

   // One rising-edge detector per synchronised detector level.
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_edge
         assign det_rise[g] = det_sync[g] & ~det_prev[g];
      end
   endgenerate

   // Rising-edge events, placed at their status bit positions.
   always_comb begin
      event_bits                = 8'h00;
      event_bits[`SCDR_BIT_BUV] = det_rise[5];
      event_bits[`SCDR_BIT_OC]  = det_rise[4];
      event_bits[`SCDR_BIT_AUV] = det_rise[3];
      event_bits[`SCDR_BIT_OT]  = det_rise[2];
      event_bits[`SCDR_BIT_OV]  = det_rise[1];
      event_bits[`SCDR_BIT_PW]  = det_rise[0];
   end

   // Clear first, then add this cycle's events, so a set in the clear
   // cycle survives and no event is lost.
   always_comb begin
      next_supply = supply_fail_status_two;
      if (frame_done && frame_mode && frame_addr == `SCDR_ADDR_SUPPLY) begin
         next_supply = 8'h00;
      end
      next_supply = (next_supply | event_bits)
                    & `SCDR_SUPPLY_MASK;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         supply_fail_status_two <= `SCDR_RST_SUPPLY;
      end else begin
         supply_fail_status_two <= next_supply;
      end
   end

   // Named views of the latched flags for the readback path.
   assign battery_undervoltage_flag       =
             supply_fail_status_two[`SCDR_BIT_BUV];
   assign aux_regulator_overcurrent_flag  =
             supply_fail_status_two[`SCDR_BIT_OC];
   assign aux_regulator_undervoltage_flag =
             supply_fail_status_two[`SCDR_BIT_AUV];
   assign aux_regulator_overtemp_flag     =
             supply_fail_status_two[`SCDR_BIT_OT];
   assign main_regulator_overvoltage_flag =
             supply_fail_status_two[`SCDR_BIT_OV];
   assign main_regulator_prewarning_flag  =
             supply_fail_status_two[`SCDR_BIT_PW];

   // Window clamp; with the limits set crossed, the upper bound wins only for a bit time above it.
   function automatic scdr_byte_t clamp_bit_time(input scdr_byte_t bt,
                                                 input scdr_byte_t hi,
                                                 input scdr_byte_t lo);
      if (bt > hi) begin
         clamp_bit_time = hi;
      end else if (bt < lo) begin
         clamp_bit_time = lo;
      end else begin
         clamp_bit_time = bt;
      end
   endfunction

   // Bit time clamped into the window set by the two limits.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         effective_bit_time <= `SCDR_RST_BTL;
      end else begin
         effective_bit_time <= clamp_bit_time(bit_time_length_setting,
                                              upper_limit_field,
                                              lower_limit_field);
      end
   end

   // Divider of the 80 MHz base that yields the recovery clock.
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         recovery_clock_div <= `SCDR_RST_DIV;
      end else begin
         case (recovery_clock_select)
            scdr_clk_80m: recovery_clock_div <= 4'h1;
            scdr_clk_40m: recovery_clock_div <= 4'h2;
            scdr_clk_20m: recovery_clock_div <= 4'h4;
            scdr_clk_10m: recovery_clock_div <= 4'h8;
            default:      recovery_clock_div <= 4'h1;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** verif/scdr_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scdr_cfg.svh"
module scdr_regs_chk (
   input wire logic                 clk_sys,
   input wire logic                 reset_n,
   input wire logic                 spi_csn_n,
   input wire logic                 spi_sdo_oe,
   input wire scdr_pkg::scdr_byte_t effective_bit_time,
   input wire scdr_pkg::scdr_clksel_e recovery_clock_select,
   input wire logic [3:0]           recovery_clock_div
);
   import scdr_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   chk_oe_cs_high: assert property (
      spi_csn_n [*4] |-> !spi_sdo_oe) else $error("sdo driven while idle");
   chk_oe_cs_low: assert property (
      !spi_csn_n [*4] |-> spi_sdo_oe) else $error("sdo not driven in frame");
   chk_div_from_sel: assert property (
      $stable(recovery_clock_select) |->
      recovery_clock_div == (4'h1 << recovery_clock_select))
      else $error("clock divider does not match select");
   chk_reset_values: assert property (
      $rose(reset_n) |-> effective_bit_time == `SCDR_RST_BTL &&
      recovery_clock_select == scdr_clk_40m && recovery_clock_div == 4'h2)
      else $error("wrong value after reset");
   chk_frame_holds_time: assert property (
      !spi_csn_n [*4] |=> $stable(effective_bit_time))
      else $error("bit time changed inside a frame");
   chk_frame_holds_sel: assert property (
      !spi_csn_n [*4] |=> $stable(recovery_clock_select))
      else $error("clock select changed inside a frame");
   chk_idle_holds_time: assert property (
      spi_csn_n [*8] |=> $stable(effective_bit_time))
      else $error("bit time changed while idle");
   chk_change_after_cs: assert property (
      $changed(effective_bit_time) |-> spi_csn_n && $past(spi_csn_n, 2))
      else $error("bit time changed without a finished frame");
endmodule
bind scdr_regs scdr_regs_chk u_chk (.clk_sys, .reset_n, .spi_csn_n,
   .spi_sdo_oe, .effective_bit_time, .recovery_clock_select,
   .recovery_clock_div);
`default_nettype wire

// *** verif/scdr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module scdr_host (
   input  wire logic clk_sys,
   input  wire logic spi_sdo,
   output var  logic spi_sck,
   output var  logic spi_csn_n,
   output var  logic spi_sdi
);
   initial begin
      spi_sck = 1'b0;
      spi_csn_n = 1'b1;
      spi_sdi = 1'b0;
   end
   // Sends nb bits MSB first with an 80 ns clock and collects bits 9 to 16.
   task automatic frame(input logic [15:0] f, input int nb,
                        output logic [7:0] q);
      q = 8'h00;
      @(posedge clk_sys);
      spi_csn_n <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         spi_sdi <= f[15 - i];
         repeat (4) @(posedge clk_sys);
         spi_sck <= 1'b1;
         if (i > 7) q = {q[6:0], spi_sdo};
         repeat (4) @(posedge clk_sys);
         spi_sck <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      spi_csn_n <= 1'b1;
      spi_sdi <= ~spi_sdi;
      repeat (8) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// *** verif/scdr_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scdr_cfg.svh"
module scdr_regs_bench;
   import scdr_pkg::*;
   logic         clk_sys = 1'b0;
   logic         reset_n = 1'b0;
   logic         spi_sck, spi_csn_n, spi_sdi, spi_sdo, spi_sdo_oe;
   logic [7:0]   det = 8'h00;
   scdr_byte_t   effective_bit_time, q, e;
   scdr_clksel_e recovery_clock_select;
   logic [3:0]   recovery_clock_div;
   scdr_byte_t   btl [5] = '{8'hc0, 8'h80, 8'ha0, 8'ha8, 8'h98};
   scdr_byte_t   eff [5] = '{8'ha8, 8'h98, 8'ha0, 8'ha8, 8'h98};
   int           n_errors = 0;
   int           total_checks = 0;
   always #5 clk_sys = ~clk_sys;
   scdr_host host (.clk_sys, .spi_sdo, .spi_sck, .spi_csn_n, .spi_sdi);
   scdr_regs dut (.clk_sys, .reset_n, .spi_sck, .spi_csn_n, .spi_sdi,
      .spi_sdo, .spi_sdo_oe, .battery_uv_det(det[6]), .aux_oc_det(det[4]),
      .aux_uv_det(det[3]), .aux_ot_det(det[2]), .main_ov_det(det[1]),
      .main_pw_det(det[0]), .effective_bit_time, .recovery_clock_select,
      .recovery_clock_div);
   task automatic chk8(input scdr_byte_t got, input scdr_byte_t exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input scdr_addr_t a, input scdr_byte_t d,
                     input int nb = 16);
      host.frame({a, 1'b1, d}, nb, q);
   endtask
   task automatic rd(input scdr_addr_t a, input scdr_byte_t exp);
      host.frame({a, 1'b0, 8'h00}, 16, q);
      chk8(q, exp);
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rd(`SCDR_ADDR_UPPER, 8'ha8);
      rd(`SCDR_ADDR_LOWER, 8'h98);
      rd(`SCDR_ADDR_SUPPLY, 8'h00);
      chk8(effective_bit_time, 8'ha0);
      wr(`SCDR_ADDR_UPPER, 8'h5a);
      rd(`SCDR_ADDR_UPPER, 8'h5a);
      chk8(effective_bit_time, 8'h5a);
      wr(`SCDR_ADDR_LOWER, 8'ha5, 12);
      rd(`SCDR_ADDR_LOWER, 8'h98);
      rd(7'h00, 8'h00);
      wr(`SCDR_ADDR_UPPER, 8'ha8);
      foreach (btl[i]) begin
         wr(`SCDR_ADDR_BTL, btl[i]);
         chk8(effective_bit_time, eff[i]);
      end
      for (int c = 0; c < 4; c++) begin
         wr(`SCDR_ADDR_CLKSEL, 8'(c));
         chk8({6'h0, recovery_clock_select}, 8'(c));
         chk8({4'h0, recovery_clock_div}, 8'h1 << c);
      end
      wr(`SCDR_ADDR_CLKSEL, 8'h01);
      for (int k = 0; k < 8; k++) begin
         det[k] <= 1'b1;
         repeat (6) @(posedge clk_sys);
         det[k] <= 1'b0;
         e = (8'h1 << k) & 8'h5f;
         rd(`SCDR_ADDR_SUPPLY, e);
         rd(`SCDR_ADDR_SUPPLY, e);
         wr(`SCDR_ADDR_SUPPLY, 8'hff);
         rd(`SCDR_ADDR_SUPPLY, 8'h00);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
